// [src/serial_ctrl_device.sv]
// Operation
// - mux bus refreshes pending bits on strobes
// - write strobe AND select opens data latch
// - one register pointer for both channels
// - unpointed access hits command or status zero
// - interrupt acknowledge works without select
// - separate transmit and receive requests per channel
// - host sets wait line rx, ready line tx
// - both channels request independently
// - software reset equals hardware reset but keeps strobe history
// - reset decode same in either shift mode
// - reset sampled on the running system clock
// - host waits four clocks after reset
// - baud source pin, system clock, or crystal
// - clock mode bit seven enables crystal
// - divisor is f over twice rate factor, minus 2
// - fifo depths four/eight, base one/three
// - frame check CRC-16 or CCITT only
// - bus variant fixed at build time
// - one extra write register, readback, no new reads
// - auto end-of-message reset and opening flag
// - ready requests follow transmit buffer room
// - host leaves four clocks between accesses
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_device
  import serial_ctrl_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  serial_ctrl_if.device bus_if,
  input wire logic [NCH-1:0] i_rx_tx_clock_pin_pin,
  input wire logic [NCH-1:0] i_xtal_clk,
  input wire logic [NCH-1:0] i_tx_pop,
  input wire logic [NCH-1:0] i_rx_push,
  input wire logic [NCH-1:0][7:0] i_rx_data,
  output logic [NCH-1:0][7:0] o_tx_data,
  output logic [NCH-1:0] o_tx_valid,
  output logic [NCH-1:0] o_flag_req,
  output logic [NCH-1:0] o_xtal_en,
  output logic [NCH-1:0] o_baud_clk
);
  typedef struct packed {
    logic wr_prev;
    logic rd_prev;
    logic as_prev;
    logic [3:0] ptr;
    logic [3:0] maddr;
    logic mch;
    logic mcs;
    logic [7:0] vec;
    logic [7:0] mctl;
    logic [NCH-1:0][7:0] dma;
    logic [NCH-1:0][7:0] clk;
    logic [NCH-1:0][7:0] xopt;
    logic [NCH-1:0][7:0] tcl;
    logic [NCH-1:0][7:0] tch;
    logic [NCH-1:0][16:0] cnt;
    logic [NCH-1:0][15:0] crc;
    logic [NCH-1:0] baud;
    logic [NCH-1:0] rtx_q;
    logic [NCH-1:0] xt_q;
    logic [NCH-1:0] end_of_message;
    logic [NCH-1:0] flag;
    logic [NCH-1:0] ovr;
    logic [NCH-1:0] ip;
    logic [NCH-1:0] txv;
    logic [NCH-1:0][TX_DEPTH-1:0][7:0] txq;
    logic [NCH-1:0][2:0] txn;
    logic [NCH-1:0][RX_DEPTH-1:0][7:0] rxq;
    logic [NCH-1:0][3:0] rxn;
    logic [7:0] dout;
    logic doe;
    logic int_n;
    logic [NCH-1:0] wreq_n;
    logic [NCH-1:0] dtr_n;
  } state_t;

  state_t st;
  state_t next_st;

  function automatic state_t rst_val();
    state_t r;
    r = '0;
    r.as_prev = 1'b1;
    r.mcs = 1'b1;
    r.int_n = 1'b1;
    r.wreq_n = '1;
    r.dtr_n = '1;
    for (int c = 0; c < NCH; c++) begin
      r.crc[c] = CRC_PRESET;
    end
    return r;
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d,
                                           input logic [15:0] p);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ p) : (r << 1);
    end
    return r;
  endfunction

  // strobes and data pass through the same two stages, so they stay aligned
  logic [14:0] s_pins;
  logic [3:0] s_clks;
  sync_stage #(.W(15)) u_sync_bus (
    .i_clk_sys(i_clk_sys),
    .i_ce(i_ce),
    .i_d({bus_if.as_n, bus_if.cs_n, bus_if.wr_n, bus_if.rd_n, bus_if.intack_n,
          bus_if.dc, bus_if.chan_b, bus_if.bus}),
    .o_q(s_pins)
  );
  sync_stage #(.W(4)) u_sync_clk (
    .i_clk_sys(i_clk_sys),
    .i_ce(i_ce),
    .i_d({i_rx_tx_clock_pin_pin, i_xtal_clk}),
    .o_q(s_clks)
  );

  logic s_as, s_cs, s_wr, s_rd, s_ia, s_dc, s_chb;
  logic [7:0] s_bus;
  logic [NCH-1:0] s_rtx, s_xt;
  assign {s_as, s_cs, s_wr, s_rd, s_ia, s_dc, s_chb, s_bus} = s_pins;
  assign {s_rtx, s_xt} = s_clks;

  // access decode; the mux variant uses select and address caught at the strobe
  logic sel_n, wr_act, rd_act, as_rise, ch;
  logic [3:0] idx;
  assign sel_n = MUX_BUS ? st.mcs : s_cs;
  assign wr_act = !sel_n && !s_wr;
  assign rd_act = (!sel_n || !s_ia) && !s_rd;
  assign as_rise = s_as && !st.as_prev;
  assign idx = MUX_BUS ? st.maddr : (s_dc ? REG_DATA : st.ptr);
  assign ch = MUX_BUS ? st.mch : s_chb;

  always_comb begin
    logic [NCH-1:0] tx_push, rx_pop, eom_clr, crc_clr, err_clr;
    logic swrst, tick, txroom, rxav;
    tx_push = '0;
    rx_pop = '0;
    eom_clr = '0;
    crc_clr = '0;
    err_clr = '0;
    swrst = 1'b0;
    tick = 1'b0;
    txroom = 1'b0;
    rxav = 1'b0;
    next_st = st;
    next_st.wr_prev = wr_act;
    next_st.rd_prev = rd_act;
    next_st.as_prev = s_as;
    // shift mode moves the channel bit but keeps the register index whole
    if (MUX_BUS && as_rise) begin
      next_st.maddr = st.mctl[MCTL_SHL] ? s_bus[4:1] : s_bus[3:0];
      next_st.mch = st.mctl[MCTL_SHL] ? s_bus[0] : s_bus[5];
      next_st.mcs = s_cs;
    end
    // write: data taken at the moment both strobes are seen low
    if (wr_act && !st.wr_prev) begin
      next_st.ptr = REG_CMD;
      case (idx)
        REG_CMD: begin
          if (!MUX_BUS) begin
            next_st.ptr = {s_bus[5:3] == CMD_POINT_HIGH, s_bus[2:0]};
          end
          eom_clr[ch] = s_bus[5:3] == CMD_RESET_EOM;
          crc_clr[ch] = s_bus[5:3] == CMD_RESET_CRC;
          err_clr[ch] = s_bus[5:3] == CMD_RESET_ERR;
        end
        REG_DATA: tx_push[ch] = 1'b1;
        REG_DMA: next_st.dma[ch] = s_bus;
        REG_VEC: next_st.vec = s_bus;
        REG_XOPT: if (ENHANCED) next_st.xopt[ch] = s_bus;
        REG_CLK: next_st.clk[ch] = s_bus;
        REG_TCL: next_st.tcl[ch] = s_bus;
        REG_TCH: next_st.tch[ch] = s_bus;
        REG_MCTL: begin
          if (s_bus[7:6] == MCTL_RESET) swrst = 1'b1;
          else next_st.mctl = s_bus;
        end
        default: ;
      endcase
    end
    // read: drive from the first seen edge until the strobe goes away
    if (rd_act && !st.rd_prev) begin
      next_st.doe = 1'b1;
      if (!s_ia) begin
        next_st.dout = st.vec;
      end else begin
        next_st.ptr = REG_CMD;
        case (idx)
          REG_CMD: next_st.dout = {1'b0, st.end_of_message[ch], st.ovr[ch], 2'b00,
                                   st.txn[ch] < TX_DEPTH, 1'b0, st.rxn[ch] != 4'h0};
          REG_DATA: begin
            next_st.dout = st.rxq[ch][0];
            rx_pop[ch] = 1'b1;
          end
          REG_VEC: next_st.dout = st.vec;
          REG_CRCL: next_st.dout = st.crc[ch][7:0];
          REG_CRCH: next_st.dout = st.crc[ch][15:8];
          REG_RB: next_st.dout = (ENHANCED && st.xopt[ch][XOPT_RDBK]) ? st.clk[ch] : 8'h00;
          default: next_st.dout = 8'h00;
        endcase
      end
    end else if (!rd_act) begin
      next_st.doe = 1'b0;
    end
    for (int c = 0; c < NCH; c++) begin
      // clears first, so a set in the same cycle wins
      if (eom_clr[c] || (tx_push[c] && ENHANCED && st.xopt[c][XOPT_EOM])) begin
        next_st.end_of_message[c] = 1'b0;
      end
      if (err_clr[c]) next_st.ovr[c] = 1'b0;
      if (crc_clr[c]) next_st.crc[c] = CRC_PRESET;
      if (i_tx_pop[c] && st.txn[c] != 3'h0) begin
        for (int k = 0; k < TX_DEPTH - 1; k++) begin
          next_st.txq[c][k] = st.txq[c][k+1];
        end
        next_st.txn[c] = st.txn[c] - 3'h1;
        next_st.flag[c] = 1'b0;
        if (st.txn[c] == 3'h1 && !tx_push[c]) next_st.end_of_message[c] = 1'b1;
      end
      // a byte written to a full buffer is dropped
      if (tx_push[c] && next_st.txn[c] < TX_DEPTH) begin
        if (ENHANCED && st.xopt[c][XOPT_FLAG] && st.txn[c] == 3'h0) begin
          next_st.flag[c] = 1'b1;
        end
        next_st.txq[c][next_st.txn[c]] = s_bus;
        next_st.crc[c] = crc_byte(st.crc[c], s_bus,
                                  (ENHANCED && st.xopt[c][XOPT_CCITT]) ? POLY_CCITT : POLY_16);
        next_st.txn[c] = next_st.txn[c] + 3'h1;
      end
      if (rx_pop[c] && st.rxn[c] != 4'h0) begin
        for (int k = 0; k < RX_DEPTH - 1; k++) begin
          next_st.rxq[c][k] = st.rxq[c][k+1];
        end
        next_st.rxn[c] = st.rxn[c] - 4'h1;
      end
      if (i_rx_push[c]) begin
        if (next_st.rxn[c] < RX_DEPTH) begin
          next_st.rxq[c][next_st.rxn[c]] = i_rx_data[c];
          next_st.rxn[c] = next_st.rxn[c] + 4'h1;
        end else begin
          next_st.ovr[c] = 1'b1;
        end
      end
      // baud source: pin edge, every system clock, or crystal edge
      case (st.clk[c][1:0])
        SRC_PIN: tick = s_rtx[c] && !st.rtx_q[c];
        SRC_SYS: tick = 1'b1;
        SRC_XTAL: tick = st.clk[c][CLK_XTAL] && s_xt[c] && !st.xt_q[c];
        default: tick = 1'b0;
      endcase
      // reload to divisor+1 gives divisor+2 ticks per half period
      if (tick) begin
        if (st.cnt[c] == 17'h0) begin
          next_st.cnt[c] = {1'b0, st.tch[c], st.tcl[c]} + 17'h1;
          next_st.baud[c] = !st.baud[c];
        end else begin
          next_st.cnt[c] = st.cnt[c] - 17'h1;
        end
      end
      txroom = next_st.txn[c] < TX_DEPTH;
      rxav = next_st.rxn[c] != 4'h0;
      if (!MUX_BUS || as_rise) begin
        next_st.ip[c] = (rxav && st.dma[c][DMA_RXIE]) || (txroom && st.dma[c][DMA_TXIE]);
      end
      // each channel's lines decided on its own state only
      next_st.wreq_n[c] = !(st.dma[c][DMA_WREQ_EN] &&
                            (st.dma[c][DMA_WREQ_RX] ? rxav : txroom));
      next_st.dtr_n[c] = !(st.dma[c][DMA_DTR_EN] && txroom);
      next_st.txv[c] = next_st.txn[c] != 3'h0;
    end
    next_st.int_n = !(st.mctl[MCTL_MIE] && (|next_st.ip));
    next_st.rtx_q = s_rtx;
    next_st.xt_q = s_xt;
    // keep strobe history so a held strobe does not fire again
    if (swrst) begin
      next_st = rst_val();
      next_st.wr_prev = wr_act;
      next_st.rd_prev = rd_act;
      next_st.as_prev = s_as;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st <= rst_val();
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign bus_if.dev_data = st.dout;
  assign bus_if.dev_oe = st.doe;
  assign bus_if.int_n = st.int_n;
  assign bus_if.wreq_n = st.wreq_n;
  assign bus_if.dtrreq_n = st.dtr_n;
  assign o_tx_valid = st.txv;
  assign o_flag_req = st.flag;
  assign o_baud_clk = st.baud;
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      o_tx_data[c] = st.txq[c][0];
      o_xtal_en[c] = st.clk[c][CLK_XTAL];
    end
  end
endmodule
`default_nettype wire

// [src/serial_ctrl_host.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_host
  import serial_ctrl_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  serial_ctrl_if.host bus_if,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic i_intack,
  input wire logic i_chan,
  input wire logic [3:0] i_reg,
  input wire logic [7:0] i_wdata,
  output logic o_ready,
  output logic o_rvalid,
  output logic [7:0] o_rdata
);
  typedef enum logic [2:0] {
    H_WAIT = 3'b000,
    H_IDLE = 3'b001,
    H_ADDR = 3'b010,
    H_ASHI = 3'b011,
    H_STRB = 3'b100,
    H_RECOV = 3'b101
  } hstate_t;

  typedef struct packed {
    hstate_t fsm;
    logic [3:0] cnt;
    logic ptr_ph;
    logic init;
    logic wr;
    logic ia;
    logic ch;
    logic [3:0] rg;
    logic [7:0] wd;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic as_n;
    logic ia_n;
    logic dc;
    logic chb;
    logic oe;
    logic [7:0] dat;
    logic rdy;
    logic rvalid;
    logic [7:0] rdata;
  } hst_t;

  hst_t st;
  hst_t next_st;

  function automatic hst_t hrst();
    hst_t r;
    r = '0;
    r.cs_n = 1'b1;
    r.wr_n = 1'b1;
    r.rd_n = 1'b1;
    r.as_n = 1'b1;
    r.ia_n = 1'b1;
    return r;
  endfunction

  // non-mux registers other than command and data need a pointer write first
  function automatic hst_t load_op(input hst_t s, input logic w, input logic ia,
                                   input logic c, input logic [3:0] r, input logic [7:0] d);
    hst_t n;
    n = s;
    n.wr = w;
    n.ia = ia;
    n.ch = c;
    n.rg = r;
    n.wd = d;
    n.ptr_ph = !MUX_BUS && !ia && r != REG_CMD && r != REG_DATA;
    n.fsm = (MUX_BUS && !ia) ? H_ADDR : H_STRB;
    n.cnt = 4'h0;
    return n;
  endfunction

  always_comb begin
    logic strb, rw, aph;
    strb = 1'b0;
    rw = 1'b0;
    aph = 1'b0;
    next_st = st;
    next_st.rvalid = 1'b0;
    unique case (st.fsm)
      H_WAIT: begin
        if (st.cnt == RST_WAIT - 4'h1) begin
          next_st = load_op(st, 1'b1, 1'b0, 1'b0, REG_DMA, HOST_DMA_CFG);
          next_st.init = 1'b1;
        end else begin
          next_st.cnt = st.cnt + 4'h1;
        end
      end
      H_IDLE: begin
        if (i_req) begin
          next_st = load_op(st, i_write && !i_intack, i_intack, i_chan, i_reg, i_wdata);
        end
      end
      H_ADDR: next_st.fsm = H_ASHI;
      H_ASHI: begin
        next_st.fsm = H_STRB;
        next_st.cnt = 4'h0;
      end
      H_STRB: begin
        // held long enough for the device's two sync stages and its edge
        if (st.cnt == STROBE_CYC - 4'h1) begin
          if (!st.wr && !st.ptr_ph) begin
            next_st.rdata = bus_if.bus;
            next_st.rvalid = 1'b1;
          end
          next_st.fsm = H_RECOV;
          next_st.cnt = 4'h0;
        end else begin
          next_st.cnt = st.cnt + 4'h1;
        end
      end
      H_RECOV: begin
        if (st.cnt == RECOV_CYC - 4'h1) begin
          next_st.cnt = 4'h0;
          if (st.ptr_ph) begin
            next_st.ptr_ph = 1'b0;
            next_st.fsm = H_STRB;
          end else if (st.init && !st.ch) begin
            next_st = load_op(st, 1'b1, 1'b0, 1'b1, REG_DMA, HOST_DMA_CFG);
          end else begin
            next_st.init = 1'b0;
            next_st.fsm = H_IDLE;
          end
        end else begin
          next_st.cnt = st.cnt + 4'h1;
        end
      end
      default: next_st = hrst();
    endcase
    // pins follow the next state so they come straight from flops
    strb = next_st.fsm == H_STRB;
    aph = next_st.fsm == H_ADDR || next_st.fsm == H_ASHI;
    rw = next_st.ptr_ph || next_st.wr;
    next_st.cs_n = !(aph || (strb && !next_st.ia));
    next_st.ia_n = !(strb && next_st.ia);
    next_st.wr_n = !(strb && rw);
    next_st.rd_n = !(strb && !rw);
    next_st.dc = !next_st.ptr_ph && next_st.rg == REG_DATA;
    next_st.chb = next_st.ch;
    next_st.oe = aph || (strb && rw);
    if (aph) begin
      next_st.dat = {2'b00, next_st.ch, 1'b0, next_st.rg};
    end else if (next_st.ptr_ph) begin
      next_st.dat = {2'b00, next_st.rg[3] ? CMD_POINT_HIGH : 3'h0, next_st.rg[2:0]};
    end else begin
      next_st.dat = next_st.wd;
    end
    // in the mux build interrupt pending bits only move on address strobes, so keep them coming
    if (!MUX_BUS) begin
      next_st.as_n = 1'b1;
    end else if (next_st.fsm == H_ADDR) begin
      next_st.as_n = 1'b0;
    end else if (aph || strb) begin
      next_st.as_n = 1'b1;
    end else begin
      next_st.as_n = !st.as_n;
    end
    next_st.rdy = next_st.fsm == H_IDLE;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st <= hrst();
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign bus_if.cs_n = st.cs_n;
  assign bus_if.wr_n = st.wr_n;
  assign bus_if.rd_n = st.rd_n;
  assign bus_if.as_n = st.as_n;
  assign bus_if.intack_n = st.ia_n;
  assign bus_if.dc = st.dc;
  assign bus_if.chan_b = st.chb;
  assign bus_if.host_data = st.dat;
  assign bus_if.host_oe = st.oe;
  assign o_ready = st.rdy;
  assign o_rvalid = st.rvalid;
  assign o_rdata = st.rdata;
endmodule
`default_nettype wire

// [src/serial_ctrl_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface serial_ctrl_if;
  import serial_ctrl_pkg::*;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic as_n;
  logic intack_n;
  logic dc;
  logic chan_b;
  logic [7:0] host_data;
  logic host_oe;
  logic [7:0] dev_data;
  logic dev_oe;
  logic int_n;
  logic [NCH-1:0] wreq_n;
  logic [NCH-1:0] dtrreq_n;
  logic [7:0] bus;
  // undriven bus floats high
  assign bus = dev_oe ? dev_data : (host_oe ? host_data : 8'hff);
  modport device (input cs_n, wr_n, rd_n, as_n, intack_n, dc, chan_b, bus,
                  output dev_data, dev_oe, int_n, wreq_n, dtrreq_n);
  modport host (input bus, int_n, wreq_n, dtrreq_n,
                output cs_n, wr_n, rd_n, as_n, intack_n, dc, chan_b, host_data, host_oe);
endinterface
`default_nettype wire

// [src/serial_ctrl_pkg.sv]
package serial_ctrl_pkg;
  localparam int NCH = 2;
  // build-time options of the one core
  localparam bit MUX_BUS = 1'b0;
  localparam bit ENHANCED = 1'b1;
  localparam logic [2:0] TX_DEPTH = ENHANCED ? 3'h4 : 3'h1;
  localparam logic [3:0] RX_DEPTH = ENHANCED ? 4'h8 : 4'h3;
  // register indices
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_DMA = 4'h1;
  localparam logic [3:0] REG_VEC = 4'h2;
  localparam logic [3:0] REG_CRCL = 4'h6;
  localparam logic [3:0] REG_CRCH = 4'h7;
  localparam logic [3:0] REG_XOPT = 4'h7;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_MCTL = 4'h9;
  localparam logic [3:0] REG_CLK = 4'hb;
  localparam logic [3:0] REG_TCL = 4'hc;
  localparam logic [3:0] REG_TCH = 4'hd;
  localparam logic [3:0] REG_RB = 4'he;
  // command register fields, bits [5:3] command, [2:0] pointer
  localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
  localparam logic [2:0] CMD_RESET_CRC = 3'h4;
  localparam logic [2:0] CMD_RESET_EOM = 3'h5;
  localparam logic [2:0] CMD_RESET_ERR = 3'h6;
  // master control fields
  localparam logic [1:0] MCTL_RESET = 2'h3;
  localparam int MCTL_MIE = 3;
  localparam int MCTL_SHL = 0;
  // dma control fields
  localparam int DMA_WREQ_EN = 0;
  localparam int DMA_WREQ_RX = 1;
  localparam int DMA_DTR_EN = 2;
  localparam int DMA_TXIE = 3;
  localparam int DMA_RXIE = 4;
  localparam logic [7:0] HOST_DMA_CFG = 8'h07;
  // clock mode fields
  localparam int CLK_XTAL = 7;
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_SYS = 2'h1;
  localparam logic [1:0] SRC_XTAL = 2'h2;
  // extended option fields
  localparam int XOPT_FLAG = 0;
  localparam int XOPT_EOM = 1;
  localparam int XOPT_CCITT = 2;
  localparam int XOPT_RDBK = 6;
  // status zero fields
  localparam int ST_RXAV = 0;
  localparam int ST_TXROOM = 2;
  localparam int ST_OVR = 5;
  localparam int ST_EOM = 6;
  // frame check
  localparam logic [15:0] POLY_16 = 16'h8005;
  localparam logic [15:0] POLY_CCITT = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  // timing counts in system clocks
  localparam logic [3:0] RST_WAIT = 4'h4;
  localparam logic [3:0] STROBE_CYC = 4'h5;
  localparam logic [3:0] RECOV_CYC = 4'h4;
endpackage

// [src/sync_stage.sv]
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(parameter int W = 1) (
  input wire logic i_clk_sys,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;
  // two flops; only the second is looked at
  always_ff @(posedge i_clk_sys) begin
    if (i_ce) begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule
`default_nettype wire

// [test/serial_ctrl_host_interface_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_host_interface_tb_top;
  import serial_ctrl_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [NCH-1:0] pin_clk = '0;
  logic [NCH-1:0] pop = '0;
  logic [NCH-1:0] push = '0;
  logic [NCH-1:0][7:0] rxd = '0;
  logic [NCH-1:0][7:0] txd;
  logic [NCH-1:0] txv, flag, xen, baud;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic ack = 1'b0;
  logic ch = 1'b0;
  logic [3:0] rg = 4'h0;
  logic [7:0] wd = 8'h00;
  logic rdy, rv;
  logic [7:0] rd, q;
  int miscompares = 0;
  int comparisons = 0;
  always #4 i_clk_sys = ~i_clk_sys;
  serial_ctrl_if bus_if();
  serial_ctrl_device u_serial_ctrl_device(.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_ce(ce), .bus_if(bus_if), .i_rx_tx_clock_pin_pin(pin_clk), .i_xtal_clk(pin_clk),
    .i_tx_pop(pop), .i_rx_push(push), .i_rx_data(rxd), .o_tx_data(txd),
    .o_tx_valid(txv), .o_flag_req(flag), .o_xtal_en(xen), .o_baud_clk(baud));
  serial_ctrl_host u_serial_ctrl_host(.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .i_ce(ce), .bus_if(bus_if), .i_req(req), .i_write(wr), .i_intack(ack), .i_chan(ch),
    .i_reg(rg), .i_wdata(wd), .o_ready(rdy), .o_rvalid(rv), .o_rdata(rd));
  serial_ctrl_props u_serial_ctrl_props(.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
    .cs_n(bus_if.cs_n), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n), .as_n(bus_if.as_n),
    .intack_n(bus_if.intack_n), .host_oe(bus_if.host_oe), .dev_oe(bus_if.dev_oe),
    .int_n(bus_if.int_n), .wreq_n(bus_if.wreq_n), .dtrreq_n(bus_if.dtrreq_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // all driving and sampling happens 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    if (n == 200)
      chk(8'h00, 8'h01, "ready timeout");
  endtask
  // one host request, held until the edge that sees ready high
  task automatic acc(input logic w, input logic a, input logic c, input logic [3:0] r,
                     input logic [7:0] d, output logic [7:0] o);
    int n;
    idle();
    req = 1'b1;
    wr = w;
    ack = a;
    ch = c;
    rg = r;
    wd = d;
    cyc(1);
    req = 1'b0;
    n = 0;
    while (!w && rv !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    // a read that never answers must not pass on stale data
    if (!w && n == 60)
      chk(8'h00, 8'h01, "read timeout");
    o = rd;
  endtask
  task automatic wr_reg(input logic c, input logic [3:0] r, input logic [7:0] d);
    acc(1'b1, 1'b0, c, r, d, q);
  endtask
  task automatic rd_chk(input logic a, input logic c, input logic [3:0] r, input logic [7:0] e);
    acc(1'b0, a, c, r, 8'h00, q);
    chk(q, e, "read");
  endtask
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // the whole run needs well under two thousand clocks
  initial begin
    cyc(20000);
    miscompares++;
    $display("CHECK FAILED %0t watchdog", $time);
    stop_test();
  end
  initial begin
    cyc(8);
    i_sys_rst = 1'b0;
    idle();
    chk({6'h0, bus_if.wreq_n}, 8'h03, "rx requests");
    chk({6'h0, bus_if.dtrreq_n}, 8'h00, "tx requests");
    rd_chk(1'b0, 1'b0, REG_CMD, 8'h04);
    $display("test status done");
    // fifth byte must be refused by the full fifo
    for (int k = 0; k < 5; k++)
      wr_reg(1'b0, REG_DATA, 8'(8'ha0 + k));
    idle();
    chk({6'h0, bus_if.dtrreq_n}, 8'h01, "fifo full");
    for (int k = 0; k < 4; k++) begin
      chk(txd[0], 8'(8'ha0 + k), "tx order");
      pop[0] = 1'b1;
      cyc(1);
      pop[0] = 1'b0;
      cyc(1);
    end
    chk({7'h0, txv[0]}, 8'h00, "tx empty");
    rd_chk(1'b0, 1'b0, REG_CMD, 8'h44);
    $display("test fifo done");
    wr_reg(1'b0, REG_XOPT, 8'h03);
    wr_reg(1'b0, REG_DATA, 8'h11);
    idle();
    chk({7'h0, flag[0]}, 8'h01, "opening flag");
    rd_chk(1'b0, 1'b0, REG_CMD, 8'h04);
    $display("test framing done");
    rxd[1] = 8'hc3;
    push[1] = 1'b1;
    cyc(1);
    push[1] = 1'b0;
    cyc(2);
    chk({6'h0, bus_if.wreq_n}, 8'h01, "rx request");
    rd_chk(1'b0, 1'b1, REG_DATA, 8'hc3);
    $display("test receive done");
    wr_reg(1'b0, REG_CLK, 8'h82);
    wr_reg(1'b0, REG_XOPT, 8'h43);
    rd_chk(1'b0, 1'b0, REG_RB, 8'h82);
    chk({7'h0, xen[0]}, 8'h01, "crystal enable");
    // two crystal edges: the first reloads from zero and toggles, the second counts
    q = {7'h0, baud[0]};
    repeat (2) begin
      pin_clk[0] = 1'b1;
      cyc(2);
      pin_clk[0] = 1'b0;
      cyc(2);
    end
    chk({7'h0, baud[0]}, q ^ 8'h01, "crystal ticks");
    wr_reg(1'b1, REG_CLK, 8'h01);
    idle();
    q = {7'h0, baud[1]};
    cyc(2);
    chk({7'h0, baud[1]}, q ^ 8'h01, "baud toggle");
    $display("test clock done");
    wr_reg(1'b0, REG_VEC, 8'h5a);
    rd_chk(1'b1, 1'b0, REG_CMD, 8'h5a);
    $display("test vector done");
    // transmit room on channel A with its interrupt and the master enable set
    wr_reg(1'b0, REG_DMA, 8'h0f);
    wr_reg(1'b0, REG_MCTL, 8'h08);
    idle();
    chk({7'h0, bus_if.int_n}, 8'h00, "interrupt raised");
    $display("test interrupt done");
    // preset, then one zero byte: the 16-bit polynomial gives fd02
    wr_reg(1'b1, REG_CMD, 8'h20);
    wr_reg(1'b1, REG_DATA, 8'h00);
    rd_chk(1'b0, 1'b1, REG_CRCL, 8'h02);
    rd_chk(1'b0, 1'b1, REG_CRCH, 8'hfd);
    $display("test crc done");
    // shift-left addressing and master enable kept, reset must still decode
    wr_reg(1'b0, REG_MCTL, 8'h09);
    wr_reg(1'b0, REG_MCTL, 8'hc0);
    idle();
    chk({5'h0, txv[0], flag[0], xen[0]}, 8'h00, "soft reset");
    chk({7'h0, bus_if.int_n}, 8'h01, "interrupt cleared");
    chk({6'h0, bus_if.dtrreq_n}, 8'h03, "dma cleared");
    $display("test soft reset done");
    stop_test();
  end
endmodule
`default_nettype wire

// [test/serial_ctrl_props.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_ctrl_props
  import serial_ctrl_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic as_n,
  input wire logic intack_n,
  input wire logic host_oe,
  input wire logic dev_oe,
  input wire logic int_n,
  input wire logic [NCH-1:0] wreq_n,
  input wire logic [NCH-1:0] dtrreq_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // the device drives only once the strobe has crossed its sync stages
  oe_late_a: assert property ($rose(dev_oe) |-> !$past(rd_n, 3) && !$past(rd_n))
    else $error("read data driven before strobe was synchronised");
  oe_release_a: assert property ($rose(rd_n) |-> ##[1:4] !dev_oe)
    else $error("read data not released after strobe");
  // strobe must be wide enough for the synchroniser to see it
  strobe_hold_a: assert property ($fell(rd_n && wr_n) |-> (!(rd_n && wr_n))[*5])
    else $error("strobe shorter than five clocks");
  recovery_a: assert property ($rose(rd_n && wr_n) |-> (rd_n && wr_n)[*4])
    else $error("recovery gap shorter than four clocks");
  boot_wait_a: assert property ($fell(i_sys_rst) |-> (cs_n && rd_n && wr_n)[*4])
    else $error("access started too soon after reset");
  reset_val_a: assert property ($fell(i_sys_rst) |-> int_n && &wreq_n && &dtrreq_n && !dev_oe)
    else $error("device outputs not at reset values");
  ack_sel_a: assert property ($rose(dev_oe) |-> !$past(cs_n, 3) || !$past(intack_n, 3))
    else $error("read answered without select or acknowledge");
  write_drive_a: assert property (!wr_n |-> host_oe && !dev_oe)
    else $error("write data not driven by host");
  fixed_bus_a: assert property (!MUX_BUS |-> as_n)
    else $error("address strobe used in plain bus build");
  cover property ($rose(dev_oe) && !intack_n);
  cover property ($fell(wr_n));
  cover property (dtrreq_n == 2'b00 && !dev_oe);
endmodule
`default_nettype wire
